// File: common/spibd_consts.svh
// Purpose: Offsets, field positions, reset values and timing counts of the serial block.
// Assumes: Word-aligned registers on a 32-bit Avalon-MM slave.
// Notes:   Included by its bare name.
`ifndef SPIBD_CONSTS_SVH
`define SPIBD_CONSTS_SVH
// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define SPIBD_OFS_CR1      4'h0
`define SPIBD_OFS_CR2      4'h4
`define SPIBD_OFS_SR       4'h8
`define SPIBD_OFS_DR       4'hC
// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SPIBD_CR1_ON       6
`define SPIBD_CR1_MASTER_SELECT     4
`define SPIBD_CR1_FDEN     0
`define SPIBD_CR2_SPSEL    0
`define SPIBD_CR2_SPOE     3
`define SPIBD_CR2_HALTW    1
`define SPIBD_SR_RXF       7
`define SPIBD_SR_TXE       5
`define SPIBD_SR_FLT       4
// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define SPIBD_CR1_RST      8'h00
`define SPIBD_CR2_RST      8'h00
`define SPIBD_BAUD_DIV     8'h08
`define SPIBD_NBITS        4'h8
`endif

// File: common/spibd_pkg.sv
// Purpose: Types shared by the serial block.
// Assumes: Nothing beyond SystemVerilog.
// Notes:   Constants live in spibd_consts.svh.
package spibd_pkg;
   // Pins facing the link, one group per direction
   typedef struct packed {
      logic sck;
      logic mosi;
      logic miso;
      logic ss_n;
   } spibd_pins_in_t;
   typedef struct packed {
      logic sck;
      logic sck_oe;
      logic mosi;
      logic mosi_oe;
      logic miso;
      logic miso_oe;
   } spibd_pins_out_t;
   typedef enum logic [1:0] {
      SPIBD_IDLE = 2'b00,
      SPIBD_RUN  = 2'b01,
      SPIBD_DONE = 2'b10
   } spibd_state_t;
endpackage

// File: hdl/spibd_core.sv
// Purpose: Serial block with single-pin mode, mode fault and low-power behaviour.
// Assumes: Avalon-MM slave on mclk_in; link pins synchronised by three flops.
// Notes:   Mode 0 clocking, MSB first, 8-bit frames.
`include "spibd_consts.svh"
module spibd_core (
   input  wire logic                     mclk_in,        // Module clock
   input  wire logic                     nrst_in,        // Async reset, low
   input  wire logic [3:0]               avs_address_in, // Byte address
   input  wire logic                     avs_read_in,    // Read strobe
   input  wire logic                     avs_write_in,   // Write strobe
   input  wire logic [31:0]              avs_writedata_in, // Write data
   output logic      [31:0]              avs_readdata_out, // Read data
   output logic                          avs_waitrequest_out, // Wait
   input  wire logic                     cpu_wait_in,    // CPU in wait
   input  wire logic                     cpu_stop_in,    // CPU in stop
   input  wire spibd_pkg::spibd_pins_in_t pins_in,       // Link pins in
   output spibd_pkg::spibd_pins_out_t     pins_out,      // Link pins out
   output logic                          irq_out         // Interrupt
);
   import spibd_pkg::*;
   // ----------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------
   logic [7:0]   cr1_r, cr2_r, dr_rx_r, dr_tx_r, shift_r;
   logic         flt_r, rxf_r, txe_r, tx_full_r;
   logic         sr_rd_flt_r, sr_rd_rxf_r, sr_rd_txe_r;
   logic         ack_r;
   logic [2:0]   sck_sy_r, mosi_sy_r, miso_sy_r, ss_sy_r;
   logic         sck_q, mosi_q, miso_q, ss_q, sck_prev_r;
   spibd_state_t state_r;
   logic [3:0]   bit_cnt_r;
   logic [7:0]   div_r;
   logic         msck_r, in_bit_r, pend_r, wait_hit_r, lowp_prev_r, slv_drv_r;
   logic         on, master_select, spsel, spoe, halt, lowp, frozen, wr, rd;
   logic         din, s_rise, s_fall, fault_ev, ss_active;
   assign on     = cr1_r[`SPIBD_CR1_ON];
   assign master_select   = cr1_r[`SPIBD_CR1_MASTER_SELECT];
   assign spsel  = cr2_r[`SPIBD_CR2_SPSEL];
   assign spoe   = cr2_r[`SPIBD_CR2_SPOE];
   assign halt   = cr2_r[`SPIBD_CR2_HALTW];
   assign lowp   = cpu_stop_in | (cpu_wait_in & halt);
   assign frozen = master_select & lowp;
   assign wr     = avs_write_in & ack_r;
   assign rd     = avs_read_in & ack_r;
   // ----------------------------------------------------------------------
   // Pin synchronisers: change counts when stages two and three agree
   // ----------------------------------------------------------------------
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sck_sy_r  <= 3'h0;
         mosi_sy_r <= 3'h0;
         miso_sy_r <= 3'h0;
         ss_sy_r   <= 3'h7;
         sck_q     <= 1'b0;
         mosi_q    <= 1'b0;
         miso_q    <= 1'b0;
         ss_q      <= 1'b1;
      end else begin
         sck_sy_r  <= {sck_sy_r[1:0], pins_in.sck};
         mosi_sy_r <= {mosi_sy_r[1:0], pins_in.mosi};
         miso_sy_r <= {miso_sy_r[1:0], pins_in.miso};
         ss_sy_r   <= {ss_sy_r[1:0], pins_in.ss_n};
         if (sck_sy_r[1] == sck_sy_r[2]) sck_q <= sck_sy_r[2];
         if (mosi_sy_r[1] == mosi_sy_r[2]) mosi_q <= mosi_sy_r[2];
         if (miso_sy_r[1] == miso_sy_r[2]) miso_q <= miso_sy_r[2];
         if (ss_sy_r[1] == ss_sy_r[2]) ss_q <= ss_sy_r[2];
      end
   end
   // Input data pin: single pin mode reads the pin it drives
   always_comb begin
      if (master_select) din = spsel ? mosi_q : miso_q;
      else      din = spsel ? miso_q : mosi_q;
   end
   // Clock edges: own divider as master, sampled pin as slave
   assign s_rise    = master_select ? (div_r == 8'h00 && !msck_r && state_r == SPIBD_RUN)
                           : (sck_q & ~sck_prev_r);
   assign s_fall    = master_select ? (div_r == 8'h00 && msck_r) : (~sck_q & sck_prev_r);
   assign ss_active = ~ss_q;
   assign fault_ev  = on & master_select & cr1_r[`SPIBD_CR1_FDEN] & ~ss_q;
   // ----------------------------------------------------------------------
   // Avalon slave: one wait state, then answer
   // ----------------------------------------------------------------------
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) ack_r <= 1'b0;
      else          ack_r <= (avs_read_in | avs_write_in) & ~ack_r;
   end
   assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_r;
   // Read data registered; unmapped offsets read as zero
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         avs_readdata_out <= 32'h0000_0000;
      end else if (avs_read_in & ~ack_r) begin
         unique case (avs_address_in)
            `SPIBD_OFS_CR1: avs_readdata_out <= {24'h000000, cr1_r};
            `SPIBD_OFS_CR2: avs_readdata_out <= {24'h000000, cr2_r};
            `SPIBD_OFS_SR:  avs_readdata_out <= {24'h000000, rxf_r, 1'b0, txe_r,
                                                 flt_r, 4'h0};
            `SPIBD_OFS_DR:  avs_readdata_out <= {24'h000000, dr_rx_r};
            default:        avs_readdata_out <= 32'h0000_0000;
         endcase
      end
   end
   // ----------------------------------------------------------------------
   // Control registers; fault clears master select, and output enable when single-pin is selected
   // ----------------------------------------------------------------------
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         cr1_r <= `SPIBD_CR1_RST;
         cr2_r <= `SPIBD_CR2_RST;
      end else begin
         if (wr && avs_address_in == `SPIBD_OFS_CR1) cr1_r <= avs_writedata_in[7:0];
         if (wr && avs_address_in == `SPIBD_OFS_CR2) cr2_r <= avs_writedata_in[7:0];
         if (fault_ev) begin
            cr1_r[`SPIBD_CR1_MASTER_SELECT] <= 1'b0;
            if (spsel) cr2_r[`SPIBD_CR2_SPOE] <= 1'b0;
         end
      end
   end
   // Status read arming for the two-step clearing sequences
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sr_rd_flt_r <= 1'b0;
         sr_rd_rxf_r <= 1'b0;
         sr_rd_txe_r <= 1'b0;
      end else if (rd && avs_address_in == `SPIBD_OFS_SR) begin
         sr_rd_flt_r <= flt_r;
         sr_rd_rxf_r <= rxf_r;
         sr_rd_txe_r <= txe_r;
      end else begin
         // Each arming is spent by the access it enables; a stale read must not clear a new flag
         if (wr && avs_address_in == `SPIBD_OFS_CR1) sr_rd_flt_r <= 1'b0;
         if (rd && avs_address_in == `SPIBD_OFS_DR)  sr_rd_rxf_r <= 1'b0;
         if (wr && avs_address_in == `SPIBD_OFS_DR)  sr_rd_txe_r <= 1'b0;
      end
   end
   // ----------------------------------------------------------------------
   // Fault flag: set wins over clear
   // ----------------------------------------------------------------------
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) flt_r <= 1'b0;
      else if (fault_ev) flt_r <= 1'b1;
      else if (!(master_select & cr1_r[`SPIBD_CR1_FDEN]) && !flt_r) flt_r <= 1'b0;
      else if (wr && avs_address_in == `SPIBD_OFS_CR1 && sr_rd_flt_r) flt_r <= 1'b0;
   end
   // ----------------------------------------------------------------------
   // Transmit data register and its empty flag
   // ----------------------------------------------------------------------
   logic load_tx;
   assign load_tx = on & ~lowp & (state_r == SPIBD_IDLE) & tx_full_r &
                    (master_select ? ~flt_r : ss_active);
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         dr_tx_r   <= 8'h00;
         tx_full_r <= 1'b0;
         txe_r     <= 1'b1;
      end else begin
         if (wr && avs_address_in == `SPIBD_OFS_DR && (sr_rd_txe_r || !txe_r)) begin
            dr_tx_r   <= avs_writedata_in[7:0];
            tx_full_r <= 1'b1;
         end else if (load_tx) begin
            tx_full_r <= 1'b0;
         end
         if (load_tx) txe_r <= 1'b1;
         else if (wr && avs_address_in == `SPIBD_OFS_DR && sr_rd_txe_r) txe_r <= 1'b0;
      end
   end
   // ----------------------------------------------------------------------
   // Shift engine
   // ----------------------------------------------------------------------
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state_r    <= SPIBD_IDLE;
         bit_cnt_r  <= 4'h0;
         shift_r    <= 8'h00;
         div_r      <= 8'h00;
         msck_r     <= 1'b0;
         in_bit_r   <= 1'b0;
         sck_prev_r <= 1'b0;
         slv_drv_r  <= 1'b0;
      end else begin
         sck_prev_r <= sck_q;
         if (fault_ev || !on || (!master_select && !ss_active && state_r != SPIBD_DONE)) begin
            state_r   <= SPIBD_IDLE;
            bit_cnt_r <= 4'h0;
            msck_r    <= 1'b0;
            div_r     <= 8'h00;
            slv_drv_r <= 1'b0;
         end else if (!frozen) begin
            unique case (state_r)
               SPIBD_IDLE: begin
                  if (load_tx) begin
                     shift_r   <= dr_tx_r;
                     state_r   <= SPIBD_RUN;
                     bit_cnt_r <= 4'h0;
                     div_r     <= `SPIBD_BAUD_DIV;
                     slv_drv_r <= 1'b1;
                  end else if (!master_select && ss_active) begin
                     // Slave selected with no new data sends back the last byte received
                     state_r   <= SPIBD_RUN;
                     bit_cnt_r <= 4'h0;
                     slv_drv_r <= 1'b1;
                  end
               end
               SPIBD_RUN: begin
                  if (master_select) div_r <= (div_r == 8'h00) ? `SPIBD_BAUD_DIV : div_r - 8'h01;
                  if (master_select && div_r == 8'h00) msck_r <= ~msck_r;
                  if (s_rise) in_bit_r <= din;
                  if (s_fall) begin
                     shift_r   <= {shift_r[6:0], in_bit_r};
                     bit_cnt_r <= bit_cnt_r + 4'h1;
                     if (bit_cnt_r == `SPIBD_NBITS - 4'h1) state_r <= SPIBD_DONE;
                  end
               end
               SPIBD_DONE: state_r <= SPIBD_IDLE;
               default:    state_r <= SPIBD_IDLE;
            endcase
         end
      end
   end
   // ----------------------------------------------------------------------
   // Receive copy, deferred while a slave is in low power entered mid-frame
   // ----------------------------------------------------------------------
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         dr_rx_r     <= 8'h00;
         rxf_r       <= 1'b0;
         pend_r      <= 1'b0;
         wait_hit_r  <= 1'b0;
         lowp_prev_r <= 1'b0;
      end else begin
         lowp_prev_r <= lowp;
         if (lowp != lowp_prev_r && state_r != SPIBD_IDLE) wait_hit_r <= 1'b1;
         if (fault_ev) pend_r <= 1'b0;
         else if (state_r == SPIBD_DONE && (master_select || !lowp)) begin
            dr_rx_r <= shift_r;
            pend_r  <= 1'b0;
         end else if (state_r == SPIBD_DONE) begin
            pend_r  <= 1'b1;
         end else if (lowp && !lowp_prev_r) begin
            pend_r  <= 1'b0;
         end
         if (!lowp && lowp_prev_r && pend_r && wait_hit_r) begin
            dr_rx_r    <= shift_r;
            pend_r     <= 1'b0;
            wait_hit_r <= 1'b0;
         end else if (!lowp && lowp_prev_r) begin
            wait_hit_r <= 1'b0;
         end
         if ((state_r == SPIBD_DONE && (master_select || !lowp) && !fault_ev) ||
             (!lowp && lowp_prev_r && pend_r && wait_hit_r)) rxf_r <= 1'b1;
         else if (rd && avs_address_in == `SPIBD_OFS_DR && sr_rd_rxf_r) rxf_r <= 1'b0;
      end
   end
   // ----------------------------------------------------------------------
   // Pin drivers: fault leaves everything as inputs
   // ----------------------------------------------------------------------
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         pins_out <= '0;
      end else begin
         pins_out.sck     <= msck_r;
         pins_out.sck_oe  <= on & master_select & ~flt_r;
         pins_out.mosi    <= shift_r[7];
         pins_out.miso    <= shift_r[7];
         pins_out.mosi_oe <= on & master_select & ~flt_r & (~spsel | spoe);
         pins_out.miso_oe <= on & ~master_select & ~flt_r & ss_active & slv_drv_r &
                             (~spsel | spoe);
      end
   end
   // Interrupt: OR of flags, only while the block is on
   assign irq_out = on & (flt_r | rxf_r | txe_r);
endmodule

// File: testbench/spibd_chk_sva.sv
// Purpose: Port-level assertions for the serial block.
// Assumes: One wait state per access; CR1 and CR2 shadowed from taken writes.
// Notes:   A fault clears the master bit behind the shadow, so checks avoid it.
`include "spibd_consts.svh"
module spibd_chk (
   input wire logic                       mclk_in,             // Clock
   input wire logic                       nrst_in,             // Reset, low
   input wire logic [3:0]                 avs_address_in,      // Address
   input wire logic                       avs_read_in,         // Read
   input wire logic                       avs_write_in,        // Write
   input wire logic [31:0]                avs_writedata_in,    // Write data
   input wire logic [31:0]                avs_readdata_out,    // Read data
   input wire logic                       avs_waitrequest_out, // Wait
   input wire spibd_pkg::spibd_pins_out_t pins_out,            // Link pins out
   input wire logic                       irq_out              // Interrupt
);
   timeunit 1ns;
   timeprecision 100ps;
   import spibd_pkg::*;
   // ----------------------------------------------------------------------
   // Shadows
   // ----------------------------------------------------------------------
   logic [7:0] cr1_r;
   logic [7:0] cr2_r;
   logic [7:0] rd;
   logic       ever_r;
   logic       flt_r;
   logic       tk_wr;
   logic       tk_rd;
   logic       sr_rd;
   assign tk_wr = avs_write_in && !avs_waitrequest_out;
   assign tk_rd = avs_read_in && !avs_waitrequest_out;
   assign sr_rd = tk_rd && avs_address_in == `SPIBD_OFS_SR;
   assign rd = avs_readdata_out[7:0];
   // Control shadows follow taken writes only
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         cr1_r <= `SPIBD_CR1_RST;
         cr2_r <= `SPIBD_CR2_RST;
      end else if (tk_wr && avs_address_in == `SPIBD_OFS_CR1) begin
         cr1_r <= avs_writedata_in[7:0];
      end else if (tk_wr && avs_address_in == `SPIBD_OFS_CR2) begin
         cr2_r <= avs_writedata_in[7:0];
      end
   end
   // Master ever chosen; a fault seen by software lasts until a CR1 write
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         ever_r <= 1'b0;
         flt_r <= 1'b0;
      end else begin
         ever_r <= ever_r | cr1_r[`SPIBD_CR1_MASTER_SELECT];
         flt_r <= (flt_r | (sr_rd & rd[`SPIBD_SR_FLT]))
                  & ~(tk_wr && avs_address_in == `SPIBD_OFS_CR1);
      end
   end
   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   a_one_wait: assert property (@(posedge mclk_in) disable iff (!nrst_in)
      $rose(avs_read_in || avs_write_in) |-> avs_waitrequest_out ##1 !avs_waitrequest_out)
      else $error("bus answer not after one wait state");
   a_high_zero: assert property (@(posedge mclk_in) disable iff (!nrst_in)
      tk_rd |-> avs_readdata_out[31:8] == 24'h000000) else $error("upper read bits set");
   a_irq_off: assert property (@(posedge mclk_in) disable iff (!nrst_in)
      !cr1_r[`SPIBD_CR1_ON] |-> !irq_out) else $error("interrupt while block off");
   a_irq_flags: assert property (@(posedge mclk_in) disable iff (!nrst_in)
      sr_rd && cr1_r[`SPIBD_CR1_ON] && (rd[7] || rd[5] || rd[4]) |-> irq_out)
      else $error("flag set without interrupt");
   a_fault_pins: assert property (@(posedge mclk_in) disable iff (!nrst_in)
      sr_rd && rd[`SPIBD_SR_FLT] |-> !pins_out.sck_oe && !pins_out.mosi_oe && !pins_out.miso_oe)
      else $error("pin driven during fault");
   a_fault_mst: assert property (@(posedge mclk_in) disable iff (!nrst_in)
      tk_rd && avs_address_in == `SPIBD_OFS_CR1 && flt_r |-> !rd[`SPIBD_CR1_MASTER_SELECT])
      else $error("master bit kept after fault");
   a_slave_calm: assert property (@(posedge mclk_in) disable iff (!nrst_in)
      sr_rd && !ever_r |-> !rd[`SPIBD_SR_FLT]) else $error("fault raised as slave");
   a_slave_sck: assert property (@(posedge mclk_in) disable iff (!nrst_in)
      !cr1_r[`SPIBD_CR1_MASTER_SELECT] && !$past(cr1_r[`SPIBD_CR1_MASTER_SELECT]) |-> !pins_out.sck_oe)
      else $error("clock driven as slave");
   a_one_pin: assert property (@(posedge mclk_in) disable iff (!nrst_in)
      cr2_r[`SPIBD_CR2_SPSEL] && cr1_r[`SPIBD_CR1_MASTER_SELECT] && cr1_r[`SPIBD_CR1_ON]
      |=> !pins_out.miso_oe) else $error("slave data pin used by master");
endmodule
bind spibd_core spibd_chk chk_u (
   .mclk_in(mclk_in), .nrst_in(nrst_in), .avs_address_in(avs_address_in),
   .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
   .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
   .avs_waitrequest_out(avs_waitrequest_out), .pins_out(pins_out), .irq_out(irq_out)
);

// File: testbench/spibd_peer.sv
// Purpose: Far side of the link: a slave answering the block, or a master driving it.
// Assumes: Mode 0, MSB first, 8-bit frames; link clock period 160 ns when it is master.
// Notes:   A released data line shows the inverse of its last value.
module spibd_peer (
   input  wire logic       dev_sck_in,  // Link clock level
   input  wire logic       dev_mosi_in, // Master data level
   input  wire logic       dev_miso_in, // Slave data level
   input  wire logic       slv_en_in,   // Answer as selected slave
   input  wire logic [7:0] tx_in,       // Byte to send
   output logic            ss_n_out,    // Select to the block
   output logic            sck_out,     // Clock when master
   output logic            mosi_out,    // Data when master
   output logic            miso_out,    // Data when slave
   output logic [7:0]      rx_out       // Last byte taken
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] sh_r;
   initial begin
      ss_n_out = 1'b1;
      sck_out = 1'b0;
      mosi_out = 1'b0;
      miso_out = 1'b0;
      rx_out = 8'h00;
      sh_r = 8'h00;
   end
   // Slave side: load on select, take on rising clock, shift on falling
   always @(posedge slv_en_in) begin
      sh_r = tx_in;
      miso_out = tx_in[7];
   end
   always @(posedge dev_sck_in) if (slv_en_in) rx_out = {rx_out[6:0], dev_mosi_in};
   always @(negedge dev_sck_in) if (slv_en_in) begin
      sh_r = {sh_r[6:0], 1'b0};
      miso_out = sh_r[7];
   end
   always @(negedge slv_en_in) miso_out = ~miso_out;
   // Master side: clock stands low between frames; offset keeps it off the block's edges
   task automatic send(input logic [7:0] b);
      int i;
      #3;
      ss_n_out = 1'b0;
      for (i = 7; i >= 0; i--) begin
         mosi_out = b[i];
         #80;
         sck_out = 1'b1;
         rx_out = {rx_out[6:0], dev_miso_in};
         #80;
         sck_out = 1'b0;
      end
      #80;
      ss_n_out = 1'b1;
      mosi_out = ~mosi_out;
   endtask
   task automatic select(input logic v);
      #3;
      ss_n_out = v;
   endtask
endmodule

// File: testbench/tb_top.sv
// Purpose: Self-checking bench for the serial block.
// Assumes: Avalon master waits for waitrequest low; 10 ns clock.
// Notes:   Wait and stop are entered in mid-frame, once as master and once as slave.
`include "spibd_consts.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import spibd_pkg::*;
   typedef struct packed {
      logic [3:0] a;
      logic [7:0] d;
      logic [7:0] e;
   } spibd_row_t;
   spibd_row_t      rows [4] = '{'{`SPIBD_OFS_CR1, 8'h01, 8'h01}, '{`SPIBD_OFS_CR1, 8'h00, 8'h00},
                                 '{`SPIBD_OFS_CR2, 8'h0B, 8'h0B}, '{`SPIBD_OFS_CR2, 8'h00, 8'h00}};
   logic            mclk_in, nrst_in, av_r, av_w, wq, irq, p_en, p_ss, p_sck, p_mosi, p_miso;
   logic            cpu_wait, cpu_stop;
   logic [3:0]      av_a;
   logic [31:0]     av_wd, av_rd;
   logic [7:0]      p_tx, p_rx, q;
   spibd_pins_in_t  pin_i;
   spibd_pins_out_t pin_o;
   int              mismatches, check_count, n;
   // Each line carries whoever drives it
   assign pin_i = {pin_o.sck_oe ? pin_o.sck : p_sck, pin_o.mosi_oe ? pin_o.mosi : p_mosi,
                   pin_o.miso_oe ? pin_o.miso : p_miso, p_ss};
   spibd_core dut_u (.mclk_in(mclk_in), .nrst_in(nrst_in), .avs_address_in(av_a),
      .avs_read_in(av_r), .avs_write_in(av_w), .avs_writedata_in(av_wd),
      .avs_readdata_out(av_rd), .avs_waitrequest_out(wq), .cpu_wait_in(cpu_wait),
      .cpu_stop_in(cpu_stop), .pins_in(pin_i), .pins_out(pin_o), .irq_out(irq));
   spibd_peer peer_u (.dev_sck_in(pin_i.sck), .dev_mosi_in(pin_i.mosi), .dev_miso_in(pin_i.miso),
      .slv_en_in(p_en), .tx_in(p_tx), .ss_n_out(p_ss), .sck_out(p_sck), .mosi_out(p_mosi),
      .miso_out(p_miso), .rx_out(p_rx));
   initial begin
      mclk_in = 1'b0;
      forever #5 mclk_in = ~mclk_in;
   end
   // One access: hold everything until waitrequest is seen low at an edge
   task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk_in);
      av_a <= a;
      av_wd <= {24'h000000, d};
      av_w <= wr;
      av_r <= ~wr;
      do @(posedge mclk_in); while (wq !== 1'b0);
      q = av_rd[7:0];
      av_w <= 1'b0;
      av_r <= 1'b0;
   endtask
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // Hang guard, far above the thousand or so cycles the run needs
   initial begin
      #200000;
      mismatches++;
      summarize();
   end
   initial begin
      {nrst_in, av_r, av_w, av_a, av_wd, p_en, p_tx, cpu_wait, cpu_stop} = '0;
      repeat (8) @(posedge mclk_in);
      nrst_in <= 1'b1;
      foreach (rows[i]) begin
         bus(1'b1, rows[i].a, rows[i].d);
         bus(1'b0, rows[i].a, 8'h00);
         chk("reg_row", rows[i].e, q);
      end
      chk("irq_off", 8'h00, {7'h00, irq});
      // Slave with fault detect on: select low must not fault
      bus(1'b1, `SPIBD_OFS_CR1, 8'h41);
      bus(1'b0, `SPIBD_OFS_SR, 8'h00);
      chk("sr_idle", 8'h20, q);
      bus(1'b1, `SPIBD_OFS_DR, 8'hA5);
      peer_u.send(8'h3C);
      repeat (10) @(posedge mclk_in);
      bus(1'b0, `SPIBD_OFS_SR, 8'h00);
      chk("slv_rxf", 8'h01, {7'h00, q[7]});
      chk("slv_flt", 8'h00, {7'h00, q[4]});
      chk("slv_out", 8'hA5, p_rx);
      bus(1'b0, `SPIBD_OFS_DR, 8'h00);
      chk("slv_in", 8'h3C, q);
      bus(1'b0, `SPIBD_OFS_SR, 8'h00);
      chk("rxf_clr", 8'h00, {7'h00, q[7]});
      // Master without fault detect while select is held low
      p_tx <= 8'h5A;
      peer_u.select(1'b0);
      p_en <= 1'b1;
      bus(1'b1, `SPIBD_OFS_CR1, 8'h50);
      bus(1'b0, `SPIBD_OFS_SR, 8'h00);
      bus(1'b1, `SPIBD_OFS_DR, 8'h96);
      n = 0;
      do begin
         bus(1'b0, `SPIBD_OFS_SR, 8'h00);
         n++;
      end while (q[7] !== 1'b1 && n < 200);
      chk("mst_flt", 8'h00, {7'h00, q[4]});
      bus(1'b0, `SPIBD_OFS_DR, 8'h00);
      chk("mst_in", 8'h5A, q);
      chk("mst_out", 8'h96, p_rx);
      peer_u.select(1'b1);
      p_en <= 1'b0;
      // Single-pin master, then a fault from a second master
      bus(1'b1, `SPIBD_OFS_CR2, 8'h09);
      bus(1'b1, `SPIBD_OFS_CR1, 8'h51);
      repeat (4) @(posedge mclk_in);
      chk("oe_one", 8'h02, {6'h00, pin_o.mosi_oe, pin_o.miso_oe});
      peer_u.select(1'b0);
      repeat (8) @(posedge mclk_in);
      chk("irq_flt", 8'h01, {7'h00, irq});
      chk("oe_none", 8'h00, {5'h00, pin_o.sck_oe, pin_o.mosi_oe, pin_o.miso_oe});
      bus(1'b0, `SPIBD_OFS_SR, 8'h00);
      chk("flt_set", 8'h01, {7'h00, q[4]});
      bus(1'b0, `SPIBD_OFS_CR1, 8'h00);
      chk("cr1_flt", 8'h41, q);
      bus(1'b0, `SPIBD_OFS_CR2, 8'h00);
      chk("cr2_flt", 8'h01, q);
      peer_u.select(1'b1);
      bus(1'b1, `SPIBD_OFS_CR1, 8'h41);
      bus(1'b0, `SPIBD_OFS_SR, 8'h00);
      chk("flt_clr", 8'h00, {7'h00, q[4]});
      // Halt in wait: a master frame freezes long past its normal length, then ends
      p_tx <= 8'hC3;
      bus(1'b1, `SPIBD_OFS_CR2, 8'h02);
      bus(1'b1, `SPIBD_OFS_CR1, 8'h50);
      p_en <= 1'b1;
      bus(1'b0, `SPIBD_OFS_SR, 8'h00);
      bus(1'b1, `SPIBD_OFS_DR, 8'h69);
      repeat (40) @(posedge mclk_in);
      cpu_wait <= 1'b1;
      repeat (200) @(posedge mclk_in);
      bus(1'b0, `SPIBD_OFS_SR, 8'h00);
      chk("wt_frz", 8'h00, {7'h00, q[7]});
      cpu_wait <= 1'b0;
      n = 0;
      do begin
         bus(1'b0, `SPIBD_OFS_SR, 8'h00);
         n++;
      end while (q[7] !== 1'b1 && n < 200);
      bus(1'b0, `SPIBD_OFS_DR, 8'h00);
      chk("wt_in", 8'hC3, q);
      chk("wt_out", 8'h69, p_rx);
      p_en <= 1'b0;
      // Stop entered mid-frame as slave: the copy waits for wake-up
      bus(1'b1, `SPIBD_OFS_CR1, 8'h40);
      fork
         peer_u.send(8'h7E);
         begin
            repeat (60) @(posedge mclk_in);
            cpu_stop <= 1'b1;
         end
      join
      repeat (10) @(posedge mclk_in);
      bus(1'b0, `SPIBD_OFS_SR, 8'h00);
      chk("stp_def", 8'h00, {7'h00, q[7]});
      cpu_stop <= 1'b0;
      repeat (4) @(posedge mclk_in);
      bus(1'b0, `SPIBD_OFS_SR, 8'h00);
      chk("stp_rxf", 8'h01, {7'h00, q[7]});
      bus(1'b0, `SPIBD_OFS_DR, 8'h00);
      chk("stp_in", 8'h7E, q);
      // Reset in mid-run: data register reads zero again
      nrst_in <= 1'b0;
      repeat (3) @(posedge mclk_in);
      nrst_in <= 1'b1;
      bus(1'b0, `SPIBD_OFS_DR, 8'h00);
      chk("dr_rst", 8'h00, q);
      bus(1'b0, `SPIBD_OFS_SR, 8'h00);
      chk("sr_rst", 8'h20, q);
      chk("irq_rst", 8'h00, {7'h00, irq});
      summarize();
   end
endmodule
